// file: dv/papfs_pin_select_checker.sv
// concurrent checks on the port A pin function select ports
`timescale 1ns/1ps
`default_nettype none
module papfs_pin_select_checker #(
    parameter int PINS = papfs_pkg::PORT_PINS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire papfs_pkg::papfs_bus_req_type avs_req,
    input wire logic [papfs_pkg::DATA_WIDTH-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [PINS-1:0] pad_in,
    input wire papfs_pkg::papfs_pad_type pad_ctrl,
    input wire papfs_pkg::papfs_alt_type alt_drive,
    input wire logic [PINS-1:0] alt_din,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [papfs_pkg::NUM_PORTS-1:0][papfs_pkg::CFG_WIDTH-1:0] port_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] m7;
    logic [1:0] m6;
    logic done;
    assign m7 = port_cfg[0][15:14];
    assign m6 = port_cfg[0][13:12];
    assign done = avs_req.write && !avs_waitrequest;
    a_cfg_after_reset: assert property ($fell(sys_rst) |-> port_cfg == '0)
        else $error("config not clear after reset");
    a_wait_one_cycle: assert property ((avs_req.read || avs_req.write)
        && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    // port_cfg and pad_ctrl both lag the register by one edge, so they
    // line up in the same sample; pads read zero in the edge after reset
    a_alt_pass_oe: assert property (
        !$past(sys_rst) && m7 == 2'h0 |->
        pad_ctrl.out_en[7] == $past(alt_drive.oe[7]) &&
        pad_ctrl.out_val[7] == $past(alt_drive.dout[7]))
        else $error("alt mode not passed through");
    a_out_mode_drive: assert property (m7 == 2'h1 |->
        pad_ctrl.out_en[7] && !pad_ctrl.pull_en[7]) else $error("out mode");
    a_in_pull_on: assert property (m6 == 2'h2 |->
        !pad_ctrl.out_en[6] && pad_ctrl.pull_en[6]) else $error("pull on");
    a_in_pull_off: assert property (m6 == 2'h3 |->
        !pad_ctrl.out_en[6] && !pad_ctrl.pull_en[6]) else $error("pull off");
    // two quiet cycles allow for a config copy that lags the register
    a_serial_cfg_kept: assert property (!done [*2] |=>
        $stable(port_cfg[9])) else $error("serial config moved");
    c_write_done: cover property (done);
    c_pull_mode: cover property (m6 == 2'h2);
    c_out_mode: cover property (m7 == 2'h1);
endmodule : papfs_pin_select_checker
bind papfs_pin_select papfs_pin_select_checker #(.PINS(PINS)) i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pad_in(pad_in), .pad_ctrl(pad_ctrl), .alt_drive(alt_drive),
    .alt_din(alt_din), .gpio_in(gpio_in), .port_cfg(port_cfg));
`default_nettype wire

// file: dv/papfs_pin_select_tb_top.sv
// self-checking bench for the port A pin function select
`timescale 1ns/1ps
`default_nettype none
module papfs_pin_select_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    papfs_pkg::papfs_bus_req_type req = '0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic wreq;
    logic [7:0] pad_in = 8'h5A;
    logic [7:0] alt_din;
    logic [7:0] gpio_in;
    papfs_pkg::papfs_pad_type pad;
    papfs_pkg::papfs_alt_type alt = {8'h96, 8'h3C};
    logic [9:0][15:0] port_cfg;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    papfs_pin_select i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .pad_in(pad_in), .pad_ctrl(pad), .alt_drive(alt),
        .alt_din(alt_din), .gpio_in(gpio_in), .port_cfg(port_cfg));
    always #12.5 ref_clk = ~ref_clk;
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        req.address <= a;
        req.writedata <= d;
        req.read <= rd;
        req.write <= !rd;
        do @(posedge ref_clk); while (wreq !== 1'b0);
        r = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic test_reset_values;
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 6'(i * 4), 32'h0, q);
            check(q, 32'h0);
        end
    endtask : test_reset_values
    task automatic test_bank;
        for (int i = 0; i < 10; i++)
            bus(1'b0, 6'(i * 4), {16'hABCD, 16'(16'h1350 + i)}, q);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 6'(i * 4), 32'h0, q);
            check(q, {16'h0, 16'(16'h1350 + i)});
            check(port_cfg[i], 16'(16'h1350 + i));
        end
        // an unmapped word must neither store nor alias port A
        bus(1'b0, 6'h3C, 32'hFFFF, q);
        bus(1'b1, 6'h3C, 32'h0, q);
        check(q, 32'h0);
        check(port_cfg[0], 16'h1350);
        // only the low byte lane may land
        req.byteenable <= 4'h1;
        bus(1'b0, 6'h04, 32'hFFFF, q);
        req.byteenable <= 4'hF;
        bus(1'b1, 6'h04, 32'h0, q);
        check(q, 32'h13FF);
    endtask : test_bank
    task automatic test_modes;
        logic [1:0] m;
        bus(1'b0, 6'h28, 32'hA5, q);
        bus(1'b1, 6'h28, 32'h0, q);
        check(q, 32'hA5);
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            bus(1'b0, 6'h00, {16'h0, {8{m}}}, q);
            repeat (3) @(posedge ref_clk);
            check(pad.out_en, m == 2'h0 ? alt.oe : {8{m == 2'h1}});
            check(pad.pull_en, {8{m == 2'h2}});
            check(gpio_in, m[1] ? pad_in : 8'h0);
            check(alt_din, m == 2'h0 ? pad_in : 8'h0);
            if (!m[1])
                check(pad.out_val, m[0] ? 8'hA5 : alt.dout);
        end
    endtask : test_modes
    task automatic test_pin_map;
        bus(1'b0, 6'h00, 32'h6000, q);
        repeat (3) @(posedge ref_clk);
        check(pad.out_en, {2'h2, alt.oe[5:0]});
        check(pad.pull_en, 8'h40);
        bus(1'b1, 6'h30, 32'h0, q);
        check(q, {8'h0, 8'h40, 2'h2, alt.oe[5:0], 8'h3F});
        bus(1'b1, 6'h2C, 32'h0, q);
        check(q, {24'h0, pad_in});
    endtask : test_pin_map
    initial begin
        req.byteenable <= 4'hF;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        test_reset_values();
        test_bank();
        test_modes();
        test_pin_map();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        test_reset_values();
        // every pin is back in alternate mode after a mid-run reset
        check(pad.out_en, alt.oe);
        check(pad.pull_en, 8'h0);
        check(alt_din, pad_in);
        wrap_up();
    end
endmodule : papfs_pin_select_tb_top
`default_nettype wire

// file: verilog/papfs_pin_select.sv
// port A pin function select with the ten-port configuration bank
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module papfs_pin_select #(
    parameter int PINS = papfs_pkg::PORT_PINS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire papfs_pkg::papfs_bus_req_type avs_req,
    output logic [papfs_pkg::DATA_WIDTH-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [PINS-1:0] pad_in,
    output papfs_pkg::papfs_pad_type pad_ctrl,
    input wire papfs_pkg::papfs_alt_type alt_drive,
    output logic [PINS-1:0] alt_din,
    output logic [PINS-1:0] gpio_in,
    output logic [papfs_pkg::NUM_PORTS-1:0][papfs_pkg::CFG_WIDTH-1:0] port_cfg
);

    logic [papfs_pkg::NUM_PORTS-1:0][papfs_pkg::CFG_WIDTH-1:0] cfg_bank;
    logic [PINS-1:0] out_data;
    logic [PINS-1:0] pad_meta;
    logic [PINS-1:0] pad_sync;
    logic ack;
    logic access;
    logic commit;
    logic cfg_hit;
    logic [3:0] cfg_index;
    logic [papfs_pkg::CFG_WIDTH-1:0] be_mask;
    logic [papfs_pkg::DATA_WIDTH-1:0] next_readdata;
    logic [PINS-1:0] sel_alt;
    logic [PINS-1:0] sel_out;
    logic [PINS-1:0] sel_pull;
    logic [PINS-1:0] sel_in;
    papfs_pkg::papfs_pad_type next_pad;

    // one-wait-state slave: waitrequest high on the first cycle only
    assign access = avs_req.read | avs_req.write;
    assign avs_waitrequest = access & ~ack;
    assign commit = access & ack;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    // configuration registers are word aligned from offset zero upward
    always_comb begin
        cfg_index = avs_req.address[5:2];
        cfg_hit = (avs_req.address[1:0] == 2'h0) &&
            (avs_req.address <= papfs_pkg::SERIAL_PORT_PIN_CONFIG_OFFSET);
    end

    always_comb begin
        be_mask = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    end

    // ten independent configuration registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int p = 0; p < papfs_pkg::NUM_PORTS; p++) begin
                cfg_bank[p] <= papfs_pkg::CFG_RESET;
            end
        end else if (commit && avs_req.write && cfg_hit) begin
            cfg_bank[cfg_index] <= (cfg_bank[cfg_index] & ~be_mask) |
                (avs_req.writedata[papfs_pkg::CFG_WIDTH-1:0] & be_mask);
        end
    end

    // output data latch for pins in general-purpose output mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_data <= papfs_pkg::OUT_DATA_RESET;
        end else if (commit && avs_req.write && avs_req.byteenable[0] &&
            avs_req.address == papfs_pkg::PORT_A_OUT_DATA_OFFSET) begin
            out_data <= avs_req.writedata[PINS-1:0];
        end
    end

    // pad levels are asynchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pad_meta <= '0;
            pad_sync <= '0;
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    // per pin mode decode
    generate
        for (genvar n = 0; n < PINS; n++) begin : g_pin
            logic [papfs_pkg::MODE_WIDTH-1:0] mode;
            assign mode = {
                cfg_bank[papfs_pkg::PORT_A][papfs_pkg::MODE_WIDTH*n +
                    papfs_pkg::MODE_HI_BIT],
                cfg_bank[papfs_pkg::PORT_A][papfs_pkg::MODE_WIDTH*n +
                    papfs_pkg::MODE_LO_BIT]
            };
            always_comb begin
                sel_alt[n] = 1'b0;
                sel_out[n] = 1'b0;
                sel_pull[n] = 1'b0;
                sel_in[n] = 1'b0;
                case (mode)
                    papfs_pkg::MODE_ALT: begin
                        sel_alt[n] = 1'b1;
                    end
                    papfs_pkg::MODE_OUT: begin
                        sel_out[n] = 1'b1;
                    end
                    papfs_pkg::MODE_IN_PULLUP: begin
                        sel_in[n] = 1'b1;
                        sel_pull[n] = 1'b1;
                    end
                    papfs_pkg::MODE_IN_FLOAT: begin
                        sel_in[n] = 1'b1;
                        sel_pull[n] = 1'b0;
                    end
                    default: begin
                        sel_alt[n] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    // pad steering; the alternate peripheral owns the driver in mode 00
    always_comb begin
        next_pad.out_val = (sel_alt & alt_drive.dout) | (sel_out & out_data);
        next_pad.out_en = (sel_alt & alt_drive.oe) | sel_out;
        next_pad.pull_en = sel_pull;
    end

    // registered so pads never see a decode glitch after a write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pad_ctrl <= '0;
        end else begin
            pad_ctrl <= next_pad;
        end
    end

    // inputs are gated so an unselected side sees a steady zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_din <= '0;
            gpio_in <= '0;
        end else begin
            alt_din <= pad_sync & sel_alt;
            gpio_in <= pad_sync & sel_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_cfg <= '0;
        end else begin
            port_cfg <= cfg_bank;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_readdata = '0;
        if (cfg_hit) begin
            next_readdata[papfs_pkg::CFG_WIDTH-1:0] = cfg_bank[cfg_index];
        end else begin
            case (avs_req.address)
                papfs_pkg::PORT_A_OUT_DATA_OFFSET: begin
                    next_readdata[PINS-1:0] = out_data;
                end
                papfs_pkg::PORT_A_PIN_LEVEL_OFFSET: begin
                    next_readdata[PINS-1:0] = pad_sync;
                end
                papfs_pkg::PORT_A_PIN_STATE_OFFSET: begin
                    next_readdata[papfs_pkg::STATE_ALT_LSB +: PINS] = sel_alt;
                    next_readdata[papfs_pkg::STATE_OE_LSB +: PINS] =
                        pad_ctrl.out_en;
                    next_readdata[papfs_pkg::STATE_PULL_LSB +: PINS] =
                        pad_ctrl.pull_en;
                end
                default: begin
                    next_readdata = '0;
                end
            endcase
        end
    end

    // captured in the wait cycle, stands on the completing edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_req.read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

endmodule : papfs_pin_select
`default_nettype wire

// file: verilog/papfs_pkg.sv
// constants, field layouts and carrier types for the port A pin function select
package papfs_pkg;

    localparam int NUM_PORTS = 10;
    localparam int PORT_PINS = 8;
    localparam int CFG_WIDTH = 16;
    localparam int ADDR_WIDTH = 6;
    localparam int DATA_WIDTH = 32;
    localparam int MODE_WIDTH = 2;

    // port index order within the configuration bank
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    localparam int PORT_H = 7;
    localparam int PORT_J = 8;
    localparam int PORT_SERIAL = 9;

    // byte addresses, one aligned word each
    localparam logic [ADDR_WIDTH-1:0] PORT_A_PIN_CONFIG_OFFSET = 6'h00;
    localparam logic [ADDR_WIDTH-1:0] PORT_B_PIN_CONFIG_OFFSET = 6'h04;
    localparam logic [ADDR_WIDTH-1:0] PORT_C_PIN_CONFIG_OFFSET = 6'h08;
    localparam logic [ADDR_WIDTH-1:0] PORT_D_PIN_CONFIG_OFFSET = 6'h0C;
    localparam logic [ADDR_WIDTH-1:0] PORT_E_PIN_CONFIG_OFFSET = 6'h10;
    localparam logic [ADDR_WIDTH-1:0] PORT_F_PIN_CONFIG_OFFSET = 6'h14;
    localparam logic [ADDR_WIDTH-1:0] PORT_G_PIN_CONFIG_OFFSET = 6'h18;
    localparam logic [ADDR_WIDTH-1:0] PORT_H_PIN_CONFIG_OFFSET = 6'h1C;
    localparam logic [ADDR_WIDTH-1:0] PORT_J_PIN_CONFIG_OFFSET = 6'h20;
    localparam logic [ADDR_WIDTH-1:0] SERIAL_PORT_PIN_CONFIG_OFFSET = 6'h24;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_OUT_DATA_OFFSET = 6'h28;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_PIN_LEVEL_OFFSET = 6'h2C;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_PIN_STATE_OFFSET = 6'h30;

    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 16'h0000;
    localparam logic [PORT_PINS-1:0] OUT_DATA_RESET = 8'h00;

    // mode field of pin n starts at bit MODE_WIDTH*n
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_HI_BIT = 1;

    localparam logic [MODE_WIDTH-1:0] MODE_ALT = 2'h0;
    localparam logic [MODE_WIDTH-1:0] MODE_OUT = 2'h1;
    localparam logic [MODE_WIDTH-1:0] MODE_IN_PULLUP = 2'h2;
    localparam logic [MODE_WIDTH-1:0] MODE_IN_FLOAT = 2'h3;

    // pin state readback layout: one byte lane per attribute
    localparam int STATE_ALT_LSB = 0;
    localparam int STATE_OE_LSB = 8;
    localparam int STATE_PULL_LSB = 16;

    typedef struct packed {
        logic [PORT_PINS-1:0] out_val;
        logic [PORT_PINS-1:0] out_en;
        logic [PORT_PINS-1:0] pull_en;
    } papfs_pad_type;

    typedef struct packed {
        logic [PORT_PINS-1:0] dout;
        logic [PORT_PINS-1:0] oe;
    } papfs_alt_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] address;
        logic read;
        logic write;
        logic [DATA_WIDTH-1:0] writedata;
        logic [DATA_WIDTH/8-1:0] byteenable;
    } papfs_bus_req_type;

endpackage : papfs_pkg
